// >>> rtl/complementary_waveform_gen.sv
`default_nettype none
`include "wavegen_map.svh"
module complementary_waveform_gen #(
  parameter int SRC_W = 4
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire wavegen_pkg::apb_req_t APB_REQ,
  output wavegen_pkg::apb_rsp_t APB_RSP,
  input wire logic PULSE_IN,
  input wire logic [SRC_W-1:0] SHUT_SRC,
  output wavegen_pkg::wave_out_t WAVE_OUT,
  output logic IRQ
);
  import wavegen_pkg::*;

  // Register state
  logic en_q, en_d;
  wg_mode_t mode_q, mode_d;
  logic [3:0] pol_q, pol_d;
  logic [`WG_DB_W-1:0] dbr_q, dbr_d, dbf_q, dbf_d;
  logic dbr_en_q, dbr_en_d, dbf_en_q, dbf_en_d;
  logic [SRC_W-1:0] src_en_q, src_en_d;
  logic restart_q, restart_d;
  logic [7:0] ovr_q, ovr_d;
  logic soft_q, soft_d;
  logic [3:0] steer_q, steer_d;
  logic [1:0] stat_q, stat_d, mask_q, mask_d;
  apb_rsp_t rsp_q, rsp_d;
  logic irq_q, irq_d;
  sd_state_t sd_q, sd_d;
  wave_out_t out_q, out_d;
  logic [3:0] steer_live_q, steer_live_d;
  logic pulse_prev_q, pulse_prev_d;
  logic pp_q, pp_d;
  logic mode_ok;
  logic wr, rd, fault, ev_shut, ev_restart;
  logic rise_del, fall_del;

  // Override code per pin: 0 inactive, 1 active, 2 drive low, 3 drive high
  function automatic logic ovr_level(input logic [1:0] code, input logic pol);
    case (code)
      2'b00: ovr_level = pol;
      2'b01: ovr_level = ~pol;
      2'b10: ovr_level = 1'b0;
      default: ovr_level = 1'b1;
    endcase
  endfunction : ovr_level

  // Accepts only the six documented mode codes
  function automatic logic is_mode(input logic [2:0] m);
    is_mode = (m == MODE_HALF) || (m == MODE_PUSH) || (m == MODE_ASYNC_STEER) ||
              (m == MODE_SYNC_STEER) || (m == MODE_FB_FWD) || (m == MODE_FB_REV);
  endfunction : is_mode

  // Access-phase strobes and the live shutdown condition
  assign wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  assign rd = APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite;
  assign fault = en_q && (((SHUT_SRC & src_en_q) != '0) || soft_q);
  assign mode_ok = is_mode(APB_REQ.pwdata[`WG_CTRL0_MODE_HI:`WG_CTRL0_MODE_LO]);

  // Dead-band timers: A path delays rise, B path delays input fall
  deadband_timer #(.W(`WG_DB_W)) u_rise (
    .CLK(CLK),
    .RST_B(RST_B),
    .run(en_q),
    .enable(dbr_en_q),
    .count(dbr_q),
    .level_in(PULSE_IN),
    .level_out(rise_del)
  );
  deadband_timer #(.W(`WG_DB_W)) u_fall (
    .CLK(CLK),
    .RST_B(RST_B),
    .run(en_q),
    .enable(dbf_en_q),
    .count(dbf_q),
    .level_in(~PULSE_IN),
    .level_out(fall_del)
  );

  // Shutdown state machine
  always_comb begin
    sd_d = sd_q;
    ev_shut = 1'b0;
    ev_restart = 1'b0;
    case (sd_q)
      SD_RUN: begin
        if (fault) begin
          sd_d = SD_DOWN;
          ev_shut = 1'b1;
        end
      end
      SD_DOWN: begin
        if (!fault) begin
          sd_d = SD_WAIT;
        end
      end
      SD_WAIT: begin
        if (fault) begin
          sd_d = SD_DOWN;
        end else if (restart_q && !PULSE_IN) begin
          sd_d = SD_RUN;
          ev_restart = 1'b1;
        end else if (wr && APB_REQ.paddr == `WG_ADDR_SHUT && !APB_REQ.pwdata[`WG_SHUT_SOFT]) begin
          sd_d = SD_RUN;
          ev_restart = 1'b1;
        end
      end
      default: sd_d = SD_RUN;
    endcase
    if (!en_q) begin
      sd_d = SD_RUN;
    end
  end

  // Waveform formation per mode
  always_comb begin
    wave_out_t raw;
    logic [3:0] act;
    raw = '0;
    act = 4'h0;
    steer_live_d = steer_live_q;
    pulse_prev_d = PULSE_IN;
    // Push-pull swaps its output pair on every rising input edge, starting on A
    pp_d = pp_q;
    if (!en_q || mode_q != MODE_PUSH) begin
      pp_d = 1'b0;
    end else if (PULSE_IN && !pulse_prev_q) begin
      pp_d = ~pp_q;
    end
    // Synchronous steering takes new steering on a rising input edge
    if (mode_q == MODE_SYNC_STEER) begin
      if (PULSE_IN && !pulse_prev_q) begin
        steer_live_d = steer_q;
      end
    end else begin
      steer_live_d = steer_q;
    end
    case (mode_q)
      MODE_HALF: begin
        act = {fall_del, rise_del, fall_del, rise_del};
      end
      MODE_PUSH: begin
        // Pulses alternate between the A/C pair and the B/D pair
        act = {PULSE_IN & ~pp_d, PULSE_IN & pp_d, PULSE_IN & ~pp_d, PULSE_IN & pp_d};
      end
      MODE_ASYNC_STEER: act = {4{PULSE_IN}} & {steer_q[3], steer_q[2], steer_q[1], steer_q[0]};
      MODE_SYNC_STEER: act = {4{PULSE_IN}} & {steer_live_q[3], steer_live_q[2], steer_live_q[1], steer_live_q[0]};
      MODE_FB_FWD: act = {PULSE_IN, 1'b0, 1'b0, 1'b1} & {1'b1, 1'b0, 1'b0, rise_del | ~dbr_en_q};
      MODE_FB_REV: act = {1'b0, 1'b1, PULSE_IN, 1'b0} & {1'b0, fall_del | ~dbf_en_q | PULSE_IN, 1'b1, 1'b0};
      default: act = 4'h0;
    endcase
    // Polarity is applied after the mode logic
    raw.a = act[0] ^ pol_q[0];
    raw.b = act[1] ^ pol_q[1];
    raw.c = act[2] ^ pol_q[2];
    raw.d = act[3] ^ pol_q[3];
    out_d = raw;
    if (!en_q) begin
      out_d = {pol_q[0], pol_q[1], pol_q[2], pol_q[3]};
    end else if (sd_q != SD_RUN || fault) begin
      out_d.a = ovr_level(ovr_q[1:0], pol_q[0]);
      out_d.b = ovr_level(ovr_q[3:2], pol_q[1]);
      out_d.c = ovr_level(ovr_q[5:4], pol_q[2]);
      out_d.d = ovr_level(ovr_q[7:6], pol_q[3]);
    end
  end

  // Register file writes and sticky status
  always_comb begin
    en_d = en_q;
    mode_d = mode_q;
    pol_d = pol_q;
    dbr_d = dbr_q;
    dbf_d = dbf_q;
    dbr_en_d = dbr_en_q;
    dbf_en_d = dbf_en_q;
    src_en_d = src_en_q;
    restart_d = restart_q;
    ovr_d = ovr_q;
    soft_d = soft_q;
    steer_d = steer_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr) begin
      case (APB_REQ.paddr)
        `WG_ADDR_CTRL0: begin
          en_d = APB_REQ.pwdata[`WG_CTRL0_EN];
          // Mode is taken while disabled, or as a full-bridge direction swap
          if (mode_ok && (!en_q || ((mode_q == MODE_FB_FWD || mode_q == MODE_FB_REV) &&
              (APB_REQ.pwdata[2:0] == MODE_FB_FWD || APB_REQ.pwdata[2:0] == MODE_FB_REV)))) begin
            mode_d = wg_mode_t'(APB_REQ.pwdata[`WG_CTRL0_MODE_HI:`WG_CTRL0_MODE_LO]);
          end
        end
        `WG_ADDR_CTRL1: pol_d = APB_REQ.pwdata[3:0];
        `WG_ADDR_DBR: begin
          dbr_d = APB_REQ.pwdata[`WG_DB_W-1:0];
          dbr_en_d = APB_REQ.pwdata[`WG_DB_W];
        end
        `WG_ADDR_DBF: begin
          dbf_d = APB_REQ.pwdata[`WG_DB_W-1:0];
          dbf_en_d = APB_REQ.pwdata[`WG_DB_W];
        end
        `WG_ADDR_SHUT: begin
          src_en_d = APB_REQ.pwdata[SRC_W-1:0];
          restart_d = APB_REQ.pwdata[`WG_SHUT_RESTART];
          ovr_d = APB_REQ.pwdata[`WG_SHUT_OVR_LO+7:`WG_SHUT_OVR_LO];
          soft_d = APB_REQ.pwdata[`WG_SHUT_SOFT];
        end
        `WG_ADDR_STEER: steer_d = APB_REQ.pwdata[3:0];
        `WG_ADDR_IRQ_STAT: stat_d = stat_q & ~APB_REQ.pwdata[1:0];
        `WG_ADDR_IRQ_MASK: mask_d = APB_REQ.pwdata[1:0];
        default: ;
      endcase
    end
    // Hardware set wins over a software clear
    if (ev_shut) begin
      stat_d[`WG_IRQ_SHUT] = 1'b1;
    end
    if (ev_restart) begin
      stat_d[`WG_IRQ_RESTART] = 1'b1;
      soft_d = 1'b0;
    end
    irq_d = (stat_d & mask_d) != 2'b00;
  end

  // APB response: zero wait states, error on unmapped address
  always_comb begin
    rsp_d = '0;
    rsp_d.pready = APB_REQ.psel && !APB_REQ.penable;
    rsp_d.prdata = `WG_ZERO32;
    if (APB_REQ.psel && !APB_REQ.penable) begin
      case (APB_REQ.paddr)
        `WG_ADDR_CTRL0: rsp_d.prdata = {24'h00_0000, en_q, 4'h0, mode_q};
        `WG_ADDR_CTRL1: rsp_d.prdata = {28'h000_0000, pol_q};
        `WG_ADDR_DBR: rsp_d.prdata = {25'h000_0000, dbr_en_q, dbr_q};
        `WG_ADDR_DBF: rsp_d.prdata = {25'h000_0000, dbf_en_q, dbf_q};
        `WG_ADDR_SHUT: rsp_d.prdata = {15'h0000, soft_q, ovr_q, 3'h0, restart_q, 4'(src_en_q)};
        `WG_ADDR_STEER: rsp_d.prdata = {28'h000_0000, steer_q};
        `WG_ADDR_IRQ_STAT: rsp_d.prdata = {30'h0000_0000, stat_q};
        `WG_ADDR_IRQ_MASK: rsp_d.prdata = {30'h0000_0000, mask_q};
        `WG_ADDR_LIVE: rsp_d.prdata = {24'h00_0000, sd_q, 2'h0, out_q.a, out_q.b, out_q.c, out_q.d};
        default: rsp_d.pslverr = 1'b1;
      endcase
    end
  end

  // Register stage for all state
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      en_q <= 1'b0;
      mode_q <= MODE_HALF;
      pol_q <= 4'h0;
      dbr_q <= '0;
      dbf_q <= '0;
      dbr_en_q <= 1'b0;
      dbf_en_q <= 1'b0;
      src_en_q <= '0;
      restart_q <= 1'b0;
      ovr_q <= 8'h00;
      soft_q <= 1'b0;
      steer_q <= 4'h0;
      stat_q <= 2'h0;
      mask_q <= 2'h0;
      rsp_q <= '0;
      irq_q <= 1'b0;
      sd_q <= SD_RUN;
      out_q <= '0;
      steer_live_q <= 4'h0;
      pulse_prev_q <= 1'b0;
      pp_q <= 1'b0;
    end else begin
      en_q <= en_d;
      mode_q <= mode_d;
      pol_q <= pol_d;
      dbr_q <= dbr_d;
      dbf_q <= dbf_d;
      dbr_en_q <= dbr_en_d;
      dbf_en_q <= dbf_en_d;
      src_en_q <= src_en_d;
      restart_q <= restart_d;
      ovr_q <= ovr_d;
      soft_q <= soft_d;
      steer_q <= steer_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rsp_q <= rsp_d;
      irq_q <= irq_d;
      sd_q <= sd_d;
      out_q <= out_d;
      steer_live_q <= steer_live_d;
      pulse_prev_q <= pulse_prev_d;
      pp_q <= pp_d;
    end
  end

  assign APB_RSP = rsp_q;
  assign WAVE_OUT = out_q;
  assign IRQ = irq_q;
endmodule : complementary_waveform_gen
`default_nettype wire

// >>> rtl/deadband_timer.sv
`default_nettype none
`include "wavegen_map.svh"
// Delays the rising edge of its input by a count; falling edges pass at once
module deadband_timer #(
  parameter int W = `WG_DB_W
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic run,
  input wire logic enable,
  input wire logic [W-1:0] count,
  input wire logic level_in,
  output logic level_out
);
  logic [W-1:0] cnt_q, cnt_d;
  logic out_q, out_d;
  logic prev_q, prev_d;
  assign level_out = out_d;
  // Next state: load on input rise, count down, release at zero
  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    prev_d = level_in;
    if (!run) begin
      cnt_d = '0;
      out_d = 1'b0;
      prev_d = 1'b0;
    end else if (!level_in) begin
      cnt_d = '0;
      out_d = 1'b0;
    end else if (!enable || count == '0) begin
      out_d = 1'b1;
    end else if (!prev_q) begin
      cnt_d = count - W'(1);
      out_d = 1'b0;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end else begin
      out_d = 1'b1;
    end
  end
  // Register stage
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      cnt_q <= '0;
      out_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
      prev_q <= prev_d;
    end
  end
endmodule : deadband_timer
`default_nettype wire

// >>> rtl/wavegen_map.svh
`ifndef WAVEGEN_MAP_SVH
`define WAVEGEN_MAP_SVH
`define WG_ADDR_CTRL0 12'h000
`define WG_ADDR_CTRL1 12'h004
`define WG_ADDR_DBR 12'h008
`define WG_ADDR_DBF 12'h00C
`define WG_ADDR_SHUT 12'h010
`define WG_ADDR_STEER 12'h014
`define WG_ADDR_IRQ_STAT 12'h018
`define WG_ADDR_IRQ_MASK 12'h01C
`define WG_ADDR_LIVE 12'h020
`define WG_CTRL0_EN 7
`define WG_CTRL0_MODE_HI 2
`define WG_CTRL0_MODE_LO 0
`define WG_SHUT_SRC_HI 3
`define WG_SHUT_SRC_LO 0
`define WG_SHUT_RESTART 4
`define WG_SHUT_OVR_LO 8
`define WG_SHUT_SOFT 16
`define WG_IRQ_SHUT 0
`define WG_IRQ_RESTART 1
`define WG_DB_W 6
`define WG_ZERO32 32'h0000_0000
`endif

// >>> rtl/wavegen_pkg.sv
`default_nettype none
package wavegen_pkg;
  typedef enum logic [2:0] {
    MODE_HALF = 3'h4,
    MODE_PUSH = 3'h5,
    MODE_ASYNC_STEER = 3'h0,
    MODE_SYNC_STEER = 3'h1,
    MODE_FB_FWD = 3'h2,
    MODE_FB_REV = 3'h3
  } wg_mode_t;
  typedef enum logic [1:0] {
    SD_RUN = 2'b00,
    SD_DOWN = 2'b01,
    SD_WAIT = 2'b11
  } sd_state_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } wave_out_t;
endpackage : wavegen_pkg
`default_nettype wire

// >>> tb/switch_driver_model.sv
`default_nettype none
// Power switch legs: counts cycles with both switches of the A/B leg or of the C/D leg on
module switch_driver_model (
  input wire logic CLK,
  input wire logic ARM,
  input wire wavegen_pkg::wave_out_t WAVE,
  output int SHOOT
);
  import wavegen_pkg::*;
  // Shoot-through would short the supply, so every such cycle on either leg is counted while ARM is high
  always @(posedge CLK) begin
    if (!ARM) SHOOT <= 0;
    else if ((WAVE.a && WAVE.b) || (WAVE.c && WAVE.d)) SHOOT <= SHOOT + 1;
  end
endmodule : switch_driver_model
`default_nettype wire

// >>> tb/tb_top.sv
`default_nettype none
`include "wavegen_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import wavegen_pkg::*;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic PULSE_IN = 1'b0;
  logic arm = 1'b0;
  logic [3:0] SHUT_SRC = 4'h0;
  logic [31:0] lf = 32'h0000_d59d;
  logic [31:0] dbv [4] = '{32'h0000_0043, 32'h0000_007f, 32'h0000_0040, 32'h0000_0000};
  logic [32:0] expq [$];
  apb_req_t APB_REQ = '0;
  apb_rsp_t APB_RSP;
  wave_out_t WAVE_OUT;
  logic IRQ;
  int errors = 0;
  int checks_done = 0;
  int shoot;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // One APB transfer; a read notes its expected {pslverr, prdata}
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd, input logic [32:0] ex);
    int n;
    @(posedge CLK);
    if (!wr) expq.push_back(ex);
    APB_REQ <= '{1'b1, 1'b0, wr, ad, wd};
    @(posedge CLK);
    APB_REQ.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (APB_RSP.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      close_out();
    end
    APB_REQ <= '0;
  endtask : apb
  // Long pulses end in a settled compare, then a burst of random toggles
  task automatic run_pulses(input int n);
    for (int i = 0; i < 2 * n; i++) begin
      lf = nxt(lf);
      PULSE_IN <= i[0];
      repeat (72) @(posedge CLK);
      chk("half", WAVE_OUT, {i[0], !i[0], i[0], !i[0]});
      repeat (lf[3:0]) @(posedge CLK);
    end
    repeat (30) begin
      lf = nxt(lf);
      PULSE_IN <= lf[0];
      @(posedge CLK);
    end
  endtask : run_pulses
  complementary_waveform_gen #(.SRC_W(4)) i_complementary_waveform_gen (.CLK(CLK), .RST_B(RST_B),
    .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .PULSE_IN(PULSE_IN), .SHUT_SRC(SHUT_SRC), .WAVE_OUT(WAVE_OUT), .IRQ(IRQ));
  switch_driver_model i_switch_driver_model (.CLK(CLK), .ARM(arm), .WAVE(WAVE_OUT), .SHOOT(shoot));
  // Clock
  initial begin
    forever #5 CLK = ~CLK;
  end
  // Takes the oldest noted read result when a read completes
  always @(posedge CLK) begin
    if (APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite && APB_RSP.pready === 1'b1 && expq.size() > 0) begin
      chk("read", {APB_RSP.pslverr, APB_RSP.prdata}, expq.pop_front());
    end
  end
  // Hang guard
  initial begin
    repeat (40000) @(posedge CLK);
    errors++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    apb(1'b0, `WG_ADDR_CTRL0, `WG_ZERO32, 33'h0_0000_0004);
    apb(1'b0, 12'h040, `WG_ZERO32, 33'h1_0000_0000);
    for (int m = 0; m < 7; m++) begin
      apb(1'b1, `WG_ADDR_CTRL0, 32'(m), 33'h0);
      apb(1'b0, `WG_ADDR_CTRL0, `WG_ZERO32, (m < 6) ? 33'(m) : 33'h5);
    end
    $display("modes done");
    for (int k = 0; k < 4; k++) begin
      lf = nxt(lf);
      PULSE_IN <= lf[4];
      apb(1'b1, `WG_ADDR_CTRL1, {28'h0, lf[3:0]}, 33'h0);
      repeat (3) @(posedge CLK);
      chk("idle", WAVE_OUT, {lf[0], lf[1], lf[2], lf[3]});
    end
    $display("idle done");
    apb(1'b1, `WG_ADDR_CTRL1, `WG_ZERO32, 33'h0);
    apb(1'b1, `WG_ADDR_STEER, 32'h0000_000f, 33'h0);
    apb(1'b1, `WG_ADDR_CTRL0, 32'h0000_0084, 33'h0);
    apb(1'b1, `WG_ADDR_CTRL0, 32'h0000_0085, 33'h0);
    apb(1'b0, `WG_ADDR_CTRL0, `WG_ZERO32, 33'h0_0000_0084);
    arm <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `WG_ADDR_DBR, dbv[k], 33'h0);
      apb(1'b1, `WG_ADDR_DBF, 32'h0000_0045, 33'h0);
      run_pulses(3);
    end
    $display("half bridge done");
    apb(1'b1, `WG_ADDR_CTRL0, 32'h0000_0004, 33'h0);
    apb(1'b1, `WG_ADDR_CTRL0, 32'h0000_0082, 33'h0);
    apb(1'b1, `WG_ADDR_CTRL0, 32'h0000_0083, 33'h0);
    apb(1'b0, `WG_ADDR_CTRL0, `WG_ZERO32, 33'h0_0000_0083);
    PULSE_IN <= 1'b1;
    apb(1'b1, `WG_ADDR_CTRL0, 32'h0000_0004, 33'h0);
    apb(1'b1, `WG_ADDR_STEER, 32'h0000_0005, 33'h0);
    apb(1'b1, `WG_ADDR_CTRL0, 32'h0000_0080, 33'h0);
    repeat (3) @(posedge CLK);
    chk("async steer", WAVE_OUT, 33'ha);
    apb(1'b1, `WG_ADDR_CTRL0, 32'h0000_0004, 33'h0);
    apb(1'b1, `WG_ADDR_CTRL0, 32'h0000_0081, 33'h0);
    apb(1'b1, `WG_ADDR_STEER, 32'h0000_0009, 33'h0);
    repeat (3) @(posedge CLK);
    chk("sync hold", WAVE_OUT, 33'ha);
    PULSE_IN <= 1'b0;
    repeat (2) @(posedge CLK);
    PULSE_IN <= 1'b1;
    repeat (3) @(posedge CLK);
    chk("sync steer", WAVE_OUT, 33'h9);
    $display("steering done");
    PULSE_IN <= 1'b0;
    apb(1'b1, `WG_ADDR_CTRL0, 32'h0000_0004, 33'h0);
    apb(1'b1, `WG_ADDR_CTRL0, 32'h0000_0085, 33'h0);
    for (int k = 0; k < 4; k++) begin
      PULSE_IN <= !k[0];
      repeat (4) @(posedge CLK);
      chk("push", WAVE_OUT, k[0] ? 33'h0 : (k[1] ? 33'h5 : 33'ha));
    end
    $display("push-pull done");
    apb(1'b1, `WG_ADDR_CTRL0, 32'h0000_0004, 33'h0);
    apb(1'b1, `WG_ADDR_CTRL0, 32'h0000_0084, 33'h0);
    apb(1'b1, `WG_ADDR_IRQ_MASK, 32'h0000_0001, 33'h0);
    apb(1'b1, `WG_ADDR_SHUT, 32'h0000_0001, 33'h0);
    PULSE_IN <= 1'b1;
    repeat (72) @(posedge CLK);
    SHUT_SRC <= 4'h1;
    for (int n = 0; n < 9 && IRQ !== 1'b1; n++) @(posedge CLK);
    chk("irq", IRQ, 33'h1);
    chk("shut", WAVE_OUT, 33'h0);
    SHUT_SRC <= 4'h0;
    apb(1'b0, `WG_ADDR_IRQ_STAT, `WG_ZERO32, 33'h1);
    apb(1'b1, `WG_ADDR_IRQ_STAT, 32'h0000_0001, 33'h0);
    apb(1'b0, `WG_ADDR_IRQ_STAT, `WG_ZERO32, 33'h0);
    chk("irq off", IRQ, 33'h0);
    apb(1'b1, `WG_ADDR_SHUT, 32'h0001_1b00, 33'h0);
    repeat (4) @(posedge CLK);
    chk("override", WAVE_OUT, 33'ha);
    apb(1'b1, `WG_ADDR_SHUT, `WG_ZERO32, 33'h0);
    // The first write only lifts the software fault; restart needs a write once it is gone
    apb(1'b1, `WG_ADDR_SHUT, `WG_ZERO32, 33'h0);
    apb(1'b0, `WG_ADDR_IRQ_STAT, `WG_ZERO32, 33'h2);
    repeat (72) @(posedge CLK);
    chk("restart", WAVE_OUT, 33'ha);
    apb(1'b0, `WG_ADDR_LIVE, `WG_ZERO32, 33'h0_0000_000a);
    RST_B <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    apb(1'b0, `WG_ADDR_CTRL0, `WG_ZERO32, 33'h0_0000_0004);
    chk("reset out", WAVE_OUT, 33'h0);
    chk("shoot", 33'(shoot), 33'h0);
    $display("shutdown and reset done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire

// >>> tb/wavegen_chk_sva.sv
`default_nettype none
`include "wavegen_map.svh"
module wavegen_chk #(
  parameter int SRC_W = 4
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire wavegen_pkg::apb_req_t APB_REQ,
  input wire wavegen_pkg::apb_rsp_t APB_RSP,
  input wire logic PULSE_IN,
  input wire logic [SRC_W-1:0] SHUT_SRC,
  input wire wavegen_pkg::wave_out_t WAVE_OUT,
  input wire logic IRQ
);
  import wavegen_pkg::*;
  logic [31:0] rf_q [8];
  logic [31:0] rf_d [8];
  logic [7:0] qt_q, qt_d, hd_q, hd_d, ag_q, ag_d;
  logic dn_q, dn_d, pv_q, lg_q, lg_d, wr, cause, ok, half, p0;
  logic [3:0] inact, ovr;
  function automatic logic ov(input logic [1:0] c, input logic p);
    return c[1] ? c[0] : c[0] ^ p;
  endfunction : ov
  // Write strobe, live shutdown cause and settled-configuration qualifiers
  assign wr = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite & APB_RSP.pready;
  assign cause = |(SHUT_SRC & rf_q[4][SRC_W-1:0]);
  assign ok = ~dn_q & ~cause & ~rf_q[4][16] & (qt_q > 8'h02);
  assign half = ok & rf_q[0][7] & (rf_q[0][2:0] == 3'h4);
  assign p0 = rf_q[1][3:0] == 4'h0;
  assign inact = {rf_q[1][0], rf_q[1][1], rf_q[1][2], rf_q[1][3]};
  assign ovr = {ov(rf_q[4][9:8], rf_q[1][0]), ov(rf_q[4][11:10], rf_q[1][1]), ov(rf_q[4][13:12], rf_q[1][2]),
    ov(rf_q[4][15:14], rf_q[1][3])};
  // Shadow of written settings; refused mode writes keep the old mode
  always_comb begin
    rf_d = rf_q;
    if (wr && APB_REQ.paddr[11:5] == 7'h00) begin
      rf_d[APB_REQ.paddr[4:2]] = APB_REQ.pwdata;
    end
    if (wr && APB_REQ.paddr == `WG_ADDR_CTRL0 && (APB_REQ.pwdata[2:0] > 3'h5 ||
        (rf_q[0][7] && !(rf_q[0][2:1] == 2'h1 && APB_REQ.pwdata[2:1] == 2'h1)))) begin
      rf_d[0][2:0] = rf_q[0][2:0];
    end
    qt_d = wr ? 8'h00 : qt_q + {7'h00, ~&qt_q};
    hd_d = (PULSE_IN != pv_q) ? 8'h00 : hd_q + {7'h00, ~&hd_q};
    ag_d = PULSE_IN ? ag_q + {7'h00, ~&ag_q} : 8'h00;
    lg_d = PULSE_IN & (pv_q ? lg_q : hd_q > 8'h03);
    dn_d = dn_q | cause | rf_q[4][16];
  end
  // Shadow registers, cleared with the design
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rf_q <= '{0: 32'h0000_0004, default: 32'h0000_0000};
      {qt_q, hd_q, ag_q, dn_q, lg_q, pv_q} <= '0;
    end else begin
      rf_q <= rf_d;
      {qt_q, hd_q, ag_q, dn_q, lg_q, pv_q} <= {qt_d, hd_d, ag_d, dn_d, lg_d, PULSE_IN};
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  sequence s_rise;
    $rose(PULSE_IN) && hd_q > 8'h03 ##1 PULSE_IN [*2];
  endsequence
  a_idle_level: assert property (!rf_q[0][7] && ok |-> WAVE_OUT == inact)
    else $error("idle level wrong");
  a_half_copy: assert property (half && hd_q == 8'h46 && qt_q > 8'h46 |-> WAVE_OUT ==
    {PULSE_IN ^ inact[3], !PULSE_IN ^ inact[2], PULSE_IN ^ inact[1], !PULSE_IN ^ inact[0]})
    else $error("half-bridge copy wrong");
  a_no_overlap: assert property (half && p0 |-> !(WAVE_OUT.a && WAVE_OUT.b))
    else $error("A and B overlap");
  a_zero_delay: assert property (half && p0 && (!rf_q[2][6] || rf_q[2][5:0] == 6'h00) ##0 s_rise |-> WAVE_OUT.a)
    else $error("undelayed rise late");
  a_rise_hold: assert property (half && p0 && lg_q && rf_q[2][6] && ag_q > 8'h00 &&
    ag_q < {2'h0, rf_q[2][5:0]} && qt_q > ag_q |-> !WAVE_OUT.a)
    else $error("rise not delayed");
  a_rise_end: assert property (half && p0 && lg_q && rf_q[2][6] &&
    ag_q == {2'h0, rf_q[2][5:0]} + 8'h03 && qt_q > ag_q |-> WAVE_OUT.a)
    else $error("delayed rise missing");
  a_shut_fast: assert property (rf_q[0][7] && p0 && rf_q[4][15:8] == 8'h00 && qt_q > 8'h02 && cause
    |-> ##[0:2] WAVE_OUT == 4'h0)
    else $error("drive not ended");
  a_override: assert property (rf_q[0][7] && rf_q[4][16] && qt_q > 8'h03 |-> WAVE_OUT == ovr)
    else $error("override level wrong");
  a_irq_set: assert property (rf_q[0][7] && rf_q[7][0] && !dn_q && cause |-> ##[1:3] IRQ)
    else $error("interrupt missing");
endmodule : wavegen_chk
bind complementary_waveform_gen wavegen_chk #(.SRC_W(SRC_W)) i_wavegen_chk (.CLK(CLK), .RST_B(RST_B),
  .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .PULSE_IN(PULSE_IN), .SHUT_SRC(SHUT_SRC), .WAVE_OUT(WAVE_OUT), .IRQ(IRQ));
`default_nettype wire
